// >>> rtl/pmic_seq_pkg.sv
package pmic_seq_pkg;

  // Clock
  localparam int CLK_PERIOD_PS = 4000;

  // Rails, in index order
  localparam int RAILS   = 7;
  localparam int RAIL_W  = 3;
  localparam int LEVEL_W = 12;
  localparam int TIMER_W = 26;

  localparam logic [RAIL_W-1:0] RAIL_RTC    = 3'h0;
  localparam logic [RAIL_W-1:0] RAIL_MEM    = 3'h1;
  localparam logic [RAIL_W-1:0] RAIL_LDO1V8 = 3'h2;
  localparam logic [RAIL_W-1:0] RAIL_SW3V3  = 3'h3;
  localparam logic [RAIL_W-1:0] RAIL_LDO3V3 = 3'h4;
  localparam logic [RAIL_W-1:0] RAIL_CORE   = 3'h5;
  localparam logic [RAIL_W-1:0] RAIL_CPU    = 3'h6;
  localparam logic [RAIL_W-1:0] RAIL_LAST   = 3'h6;

  localparam logic [RAILS-1:0] RTC_MASK  = 7'h01;
  localparam logic [RAILS-1:0] ALL_MASK  = 7'h7F;
  localparam logic [RAILS-1:0] NONE_MASK = 7'h00;

  // Strobes 1, 2, 3, 4 and 5 after strobe 15 (the RTC rail)
  localparam int STEP_W = 3;
  localparam logic [STEP_W-1:0] STEP_FIRST = 3'h0;
  localparam logic [STEP_W-1:0] STEP_LAST  = 3'h4;
  localparam logic [STEP_W-1:0] STEP_INC   = 3'h1;
  localparam logic [RAILS-1:0] STEP_MASK [0:4] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h60};

  // Levels in millivolts
  localparam logic [LEVEL_W-1:0] MV_1V1  = 12'h44C;
  localparam logic [LEVEL_W-1:0] MV_1V35 = 12'h546;
  localparam logic [LEVEL_W-1:0] MV_1V5  = 12'h5DC;
  localparam logic [LEVEL_W-1:0] MV_1V8  = 12'h708;
  localparam logic [LEVEL_W-1:0] MV_3V3  = 12'hCE4;
  localparam logic [LEVEL_W-1:0] LEVEL_DEFAULT [0:RAILS-1] =
    '{MV_1V8, MV_1V5, MV_1V8, MV_3V3, MV_3V3, MV_1V1, MV_1V1};

  // Times and derived cycle counts
  localparam int RTC_STABLE_NS  = 10000;
  localparam int WAKE_PULSE_NS  = 1000;
  localparam int RAIL_TIMEOUT_US = 1000;
  localparam int LED_FLASH_MS    = 250;
  localparam int RTC_STABLE_CYC = (RTC_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAIL_TIMEOUT_CYC_DEF = (RAIL_TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LED_FLASH_CYC_DEF = int'((64'(LED_FLASH_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS));

  // Sequencer states
  typedef enum logic [5:0] {
    ST_OFF      = 6'h01,
    ST_RTC_UP   = 6'h02,
    ST_WAIT_REQ = 6'h04,
    ST_SEQ      = 6'h08,
    ST_ACTIVE   = 6'h10,
    ST_FAULT    = 6'h20
  } seq_state_t;

endpackage : pmic_seq_pkg

// >>> rtl/countdown_timer.sv
`timescale 1ns/100ps
`default_nettype none
module countdown_timer #(
  parameter int W = 26
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_b_in,
  // Control
  input  wire logic         start_in,
  input  wire logic [W-1:0] load_in,
  // Status
  output logic              busy_out,
  output logic              last_out,
  output logic              done_out
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         done_reg;
  logic         done_next;

  always_comb begin
    count_next = count_reg;
    done_next  = 1'b0;
    if (start_in) begin
      count_next = load_in;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
      done_next  = (count_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign busy_out = (count_reg != '0);
  assign last_out = (count_reg == {{(W-1){1'b0}}, 1'b1});
  assign done_out = done_reg;

endmodule : countdown_timer
`default_nettype wire

// >>> rtl/pmic_power_up_handshake.sv
`timescale 1ns/100ps
`default_nettype none
module pmic_power_up_handshake #(
  parameter int RAIL_TIMEOUT_CYC = pmic_seq_pkg::RAIL_TIMEOUT_CYC_DEF,
  parameter int LED_FLASH_CYC    = pmic_seq_pkg::LED_FLASH_CYC_DEF
) (
  // Clock and reset
  input  wire logic                                              sys_clk_in,
  input  wire logic                                              rst_b_in,
  // Power input, processor handshake, button and memory strap
  input  wire logic                                              power_present_in,
  input  wire logic                                              power_enable_request_in,
  input  wire logic                                              power_button_in,
  input  wire logic                                              memory_low_voltage_in,
  // Rail monitors
  input  wire logic [pmic_seq_pkg::RAILS-1:0]                    rail_good_in,
  // Decoded control_serial_bus writes
  input  wire logic                                              cmd_valid_in,
  input  wire logic [pmic_seq_pkg::RAIL_W-1:0]                   cmd_rail_in,
  input  wire logic                                              cmd_enable_in,
  input  wire logic [pmic_seq_pkg::LEVEL_W-1:0]                  cmd_level_in,
  input  wire logic                                              irq_clear_in,
  // Rail control
  output logic [pmic_seq_pkg::RAILS-1:0]                         rail_enable_out,
  output logic [pmic_seq_pkg::RAILS*pmic_seq_pkg::LEVEL_W-1:0]   rail_level_out,
  // Processor signals and power indicator
  output logic                                                   rtc_supply_good_out,
  output logic                                                   all_rails_good_out,
  output logic                                                   processor_wake_out,
  output logic                                                   event_irq_n_out,
  output logic                                                   event_irq_oe_n_out,
  output logic                                                   power_led_out
);

  localparam logic [pmic_seq_pkg::TIMER_W-1:0] RTC_LOAD   = pmic_seq_pkg::RTC_STABLE_CYC[pmic_seq_pkg::TIMER_W-1:0];
  localparam logic [pmic_seq_pkg::TIMER_W-1:0] TMO_LOAD   = RAIL_TIMEOUT_CYC[pmic_seq_pkg::TIMER_W-1:0];
  localparam logic [pmic_seq_pkg::TIMER_W-1:0] FLASH_LOAD = LED_FLASH_CYC[pmic_seq_pkg::TIMER_W-1:0];
  localparam logic [pmic_seq_pkg::TIMER_W-1:0] WAKE_LOAD  = pmic_seq_pkg::WAKE_PULSE_CYC[pmic_seq_pkg::TIMER_W-1:0];

  pmic_seq_pkg::seq_state_t                 state_reg;
  pmic_seq_pkg::seq_state_t                 state_next;
  logic [pmic_seq_pkg::STEP_W-1:0]          step_reg;
  logic [pmic_seq_pkg::STEP_W-1:0]          step_next;
  logic [pmic_seq_pkg::RAILS-1:0]           enable_reg;
  logic [pmic_seq_pkg::RAILS-1:0]           enable_next;
  logic [pmic_seq_pkg::LEVEL_W-1:0]         level_reg  [0:pmic_seq_pkg::RAILS-1];
  logic [pmic_seq_pkg::LEVEL_W-1:0]         level_next [0:pmic_seq_pkg::RAILS-1];
  logic                                     rtc_good_reg;
  logic                                     rtc_good_next;
  logic                                     all_good_reg;
  logic                                     all_good_next;
  logic                                     btn_q_reg;
  logic                                     irq_oe_n_reg;
  logic                                     irq_oe_n_next;
  logic                                     wake_reg;
  logic                                     wake_next;
  logic                                     led_reg;
  logic                                     led_next;
  logic                                     lowv_reg;
  logic                                     lowv_next;
  logic                                     strap_taken_reg;
  logic                                     press;
  logic                                     seq_start;
  logic [pmic_seq_pkg::TIMER_W-1:0]         seq_load;
  logic                                     seq_done;
  logic                                     flash_start;
  logic                                     flash_busy;
  logic                                     flash_last;
  logic                                     wake_busy;
  logic                                     wake_last;
  logic                                     cmd_ok;
  logic [pmic_seq_pkg::LEVEL_W-1:0]         mem_floor;

  // One timer serves both the RTC settle time and the per-strobe timeout
  countdown_timer #(.W(pmic_seq_pkg::TIMER_W)) seq_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (seq_start),
    .load_in    (seq_load),
    .busy_out   (),
    .last_out   (),
    .done_out   (seq_done)
  );

  countdown_timer #(.W(pmic_seq_pkg::TIMER_W)) flash_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (flash_start),
    .load_in    (FLASH_LOAD),
    .busy_out   (flash_busy),
    .last_out   (flash_last),
    .done_out   ()
  );

  countdown_timer #(.W(pmic_seq_pkg::TIMER_W)) wake_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (press),
    .load_in    (WAKE_LOAD),
    .busy_out   (wake_busy),
    .last_out   (wake_last),
    .done_out   ()
  );

  // Memory floor follows the memory type strap
  assign mem_floor = lowv_reg ? pmic_seq_pkg::MV_1V35 : pmic_seq_pkg::MV_1V5;
  // The RTC rail is never switched by software; a low memory level is refused
  assign cmd_ok = cmd_valid_in && (cmd_rail_in != pmic_seq_pkg::RAIL_RTC) && (cmd_rail_in <= pmic_seq_pkg::RAIL_LAST);

  always_comb begin
    state_next    = state_reg;
    step_next     = step_reg;
    enable_next   = enable_reg;
    rtc_good_next = rtc_good_reg;
    all_good_next = all_good_reg;
    seq_start     = 1'b0;
    seq_load      = TMO_LOAD;
    flash_start   = 1'b0;
    for (int i = 0; i < pmic_seq_pkg::RAILS; i++) begin
      level_next[i] = level_reg[i];
    end
    unique case (state_reg)
      pmic_seq_pkg::ST_OFF: begin
        if (power_present_in) begin
          state_next  = pmic_seq_pkg::ST_RTC_UP;
          enable_next = pmic_seq_pkg::RTC_MASK;
          seq_start   = 1'b1;
          seq_load    = RTC_LOAD;
        end
      end
      pmic_seq_pkg::ST_RTC_UP: begin
        if (!rail_good_in[pmic_seq_pkg::RAIL_RTC]) begin
          seq_start = 1'b1;
          seq_load  = RTC_LOAD;
        end else if (seq_done) begin
          state_next    = pmic_seq_pkg::ST_WAIT_REQ;
          rtc_good_next = 1'b1;
        end
      end
      pmic_seq_pkg::ST_WAIT_REQ: begin
        if (power_enable_request_in) begin
          state_next  = pmic_seq_pkg::ST_SEQ;
          step_next   = pmic_seq_pkg::STEP_FIRST;
          enable_next = pmic_seq_pkg::RTC_MASK | pmic_seq_pkg::STEP_MASK[pmic_seq_pkg::STEP_FIRST];
          seq_start   = 1'b1;
          for (int i = 0; i < pmic_seq_pkg::RAILS; i++) begin
            level_next[i] = pmic_seq_pkg::LEVEL_DEFAULT[i];
          end
        end
      end
      pmic_seq_pkg::ST_SEQ: begin
        if (!power_enable_request_in) begin
          state_next  = pmic_seq_pkg::ST_WAIT_REQ;
          enable_next = pmic_seq_pkg::RTC_MASK;
        end else if ((rail_good_in & enable_reg) == enable_reg) begin
          if (step_reg == pmic_seq_pkg::STEP_LAST) begin
            state_next    = pmic_seq_pkg::ST_ACTIVE;
            all_good_next = 1'b1;
          end else begin
            step_next   = step_reg + pmic_seq_pkg::STEP_INC;
            enable_next = enable_reg | pmic_seq_pkg::STEP_MASK[step_reg + pmic_seq_pkg::STEP_INC];
            seq_start   = 1'b1;
          end
        end else if (seq_done) begin
          state_next  = pmic_seq_pkg::ST_FAULT;
          enable_next = pmic_seq_pkg::RTC_MASK;
          flash_start = 1'b1;
        end
      end
      pmic_seq_pkg::ST_ACTIVE: begin
        if (!power_enable_request_in) begin
          state_next    = pmic_seq_pkg::ST_WAIT_REQ;
          enable_next   = pmic_seq_pkg::RTC_MASK;
          all_good_next = 1'b0;
        end else if (cmd_ok) begin
          enable_next[cmd_rail_in] = cmd_enable_in;
          // Core rail writes are taken as given; the processor must keep it at 1.1V
          if (!((cmd_rail_in == pmic_seq_pkg::RAIL_MEM) && (cmd_level_in < mem_floor))) begin
            level_next[cmd_rail_in] = cmd_level_in;
          end
        end
      end
      pmic_seq_pkg::ST_FAULT: begin
        // Held here until the request drops, so a stuck request cannot loop faults
        if (!power_enable_request_in) begin
          state_next = pmic_seq_pkg::ST_WAIT_REQ;
        end
      end
    endcase
    if (!power_present_in) begin
      state_next    = pmic_seq_pkg::ST_OFF;
      enable_next   = pmic_seq_pkg::NONE_MASK;
      rtc_good_next = 1'b0;
      all_good_next = 1'b0;
      flash_start   = 1'b0;
    end
  end

  // Events, indicator and strap
  assign press = power_button_in && !btn_q_reg && power_present_in;

  always_comb begin
    irq_oe_n_next = !(press || (!irq_oe_n_reg && !irq_clear_in));
    wake_next = press || (wake_busy && !wake_last);
    led_next  = (state_next == pmic_seq_pkg::ST_ACTIVE) || flash_start || (flash_busy && !flash_last);
    lowv_next = strap_taken_reg ? lowv_reg : memory_low_voltage_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_reg       <= pmic_seq_pkg::ST_OFF;
      step_reg        <= pmic_seq_pkg::STEP_FIRST;
      enable_reg      <= pmic_seq_pkg::NONE_MASK;
      rtc_good_reg    <= 1'b0;
      all_good_reg    <= 1'b0;
      btn_q_reg       <= 1'b0;
      irq_oe_n_reg    <= 1'b1;
      wake_reg        <= 1'b0;
      led_reg         <= 1'b0;
      lowv_reg        <= 1'b0;
      strap_taken_reg <= 1'b0;
      for (int i = 0; i < pmic_seq_pkg::RAILS; i++) begin
        level_reg[i] <= pmic_seq_pkg::LEVEL_DEFAULT[i];
      end
    end else begin
      state_reg       <= state_next;
      step_reg        <= step_next;
      enable_reg      <= enable_next;
      rtc_good_reg    <= rtc_good_next;
      all_good_reg    <= all_good_next;
      btn_q_reg       <= power_button_in;
      irq_oe_n_reg    <= irq_oe_n_next;
      wake_reg        <= wake_next;
      led_reg         <= led_next;
      lowv_reg        <= lowv_next;
      strap_taken_reg <= 1'b1;
      for (int i = 0; i < pmic_seq_pkg::RAILS; i++) begin
        level_reg[i] <= level_next[i];
      end
    end
  end

  assign rail_enable_out     = enable_reg;
  assign rtc_supply_good_out = rtc_good_reg;
  assign all_rails_good_out  = all_good_reg;
  assign processor_wake_out  = wake_reg;
  assign event_irq_n_out     = 1'b0;
  assign event_irq_oe_n_out  = irq_oe_n_reg;
  assign power_led_out       = led_reg;

  for (genvar g = 0; g < pmic_seq_pkg::RAILS; g++) begin : g_level
    assign rail_level_out[g*pmic_seq_pkg::LEVEL_W +: pmic_seq_pkg::LEVEL_W] = level_reg[g];
  end

  // Checks
  sequence s_press;
    power_button_in && !btn_q_reg && power_present_in;
  endsequence

  sequence s_request_drop;
    power_present_in && !power_enable_request_in && (state_reg == pmic_seq_pkg::ST_ACTIVE);
  endsequence

  a_rtc_only_first: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state_reg == pmic_seq_pkg::ST_RTC_UP) |-> (rail_enable_out == pmic_seq_pkg::RTC_MASK))
    else $error("non-RTC rail enabled before the request");

  a_rtc_good_stable: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(rtc_supply_good_out) |-> $past(rail_good_in[0], 1) && $past(rail_good_in[0], 8))
    else $error("rtc good raised without a stable rail");

  a_request_starts: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ((state_reg == pmic_seq_pkg::ST_WAIT_REQ) && power_enable_request_in && power_present_in)
      |=> (rail_enable_out == 7'h03) && (state_reg == pmic_seq_pkg::ST_SEQ))
    else $error("request did not start strobe 1");

  a_drop_powers_down: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_request_drop |=> (rail_enable_out == pmic_seq_pkg::RTC_MASK) && !all_rails_good_out)
    else $error("request drop did not power down");

  a_strobe_order: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($rose(rail_enable_out[5]) && (state_reg == pmic_seq_pkg::ST_SEQ))
      |-> rail_enable_out[6] && (rail_enable_out[4:1] == 4'hF))
    else $error("core and cpu strobe out of order");

  a_strobe_waits_good: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($rose(rail_enable_out[3]) && (state_reg == pmic_seq_pkg::ST_SEQ)) |-> $past(rail_good_in[2:1] == 2'h3))
    else $error("strobe advanced before rails good");

  a_all_good_release: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(all_rails_good_out) |-> (rail_enable_out == pmic_seq_pkg::ALL_MASK) ##1 all_rails_good_out || !power_present_in)
    else $error("all rails good without every rail");

  a_wake_on_press: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_press |=> processor_wake_out [*8])
    else $error("wake pulse missing after press");

  a_irq_press_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_press |=> (!event_irq_oe_n_out && !event_irq_n_out) ##1 (!event_irq_oe_n_out || $past(irq_clear_in)))
    else $error("interrupt not pulled low on press");

  a_irq_release: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (irq_clear_in && !(power_button_in && !btn_q_reg && power_present_in)) |=> event_irq_oe_n_out)
    else $error("interrupt line not released on clear");

  a_led_fault_flash: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($rose(state_reg == pmic_seq_pkg::ST_FAULT)) |-> power_led_out && !all_rails_good_out)
    else $error("fault did not flash the indicator");

  a_cmd_level: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ((state_reg == pmic_seq_pkg::ST_ACTIVE) && power_enable_request_in && power_present_in && cmd_valid_in
      && (cmd_rail_in == pmic_seq_pkg::RAIL_CPU)) |=> (level_reg[6] == $past(cmd_level_in)) && rail_enable_out[6] == $past(cmd_enable_in))
    else $error("cpu rail write not taken");

  a_cpu_default: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(state_reg == pmic_seq_pkg::ST_SEQ) |-> (level_reg[6] == pmic_seq_pkg::MV_1V1) && (level_reg[1] == pmic_seq_pkg::MV_1V5))
    else $error("rail defaults not loaded at power-up");

  a_mem_floor: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (level_reg[1] >= pmic_seq_pkg::MV_1V35) && (lowv_reg || (level_reg[1] >= pmic_seq_pkg::MV_1V5)))
    else $error("memory rail below its floor");

endmodule : pmic_power_up_handshake
`default_nettype wire

// >>> tb/pmic_proc_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmic_proc_model (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // From the sequencer
  input  wire logic [6:0] rail_enable_in,
  input  wire logic       rtc_supply_good_in,
  // Scenario control
  input  wire logic       want_up_in,
  input  wire logic [6:0] stuck_in,
  // To the sequencer
  output logic      [6:0] rail_good_out,
  output logic            power_enable_request_out
);
  logic [1:0] ramp_reg [0:6];

  // A rail reports good 4 cycles after enable; a stuck rail never does
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < 7; i++) begin
      if (!rst_b_in || !rail_enable_in[i] || stuck_in[i]) begin
        ramp_reg[i]      <= 2'h0;
        rail_good_out[i] <= 1'b0;
      end else if (ramp_reg[i] != 2'h3) begin
        ramp_reg[i] <= ramp_reg[i] + 2'h1;
      end else begin
        rail_good_out[i] <= 1'b1;
      end
    end
  end

  // Request only once the RTC domain is out of reset; dropping it asks for power-down
  always_ff @(posedge sys_clk_in) begin
    power_enable_request_out <= rst_b_in & rtc_supply_good_in & want_up_in;
  end
endmodule : pmic_proc_model
`default_nettype wire

// >>> tb/pmic_power_up_handshake_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pmic_power_up_handshake_tb_top;
  logic        sys_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        power_present_in = 1'b0;
  logic        power_button_in = 1'b0;
  logic        memory_low_voltage_in = 1'b0;
  logic        cmd_valid_in = 1'b0;
  logic        cmd_enable_in = 1'b0;
  logic        irq_clear_in = 1'b0;
  logic        want_up = 1'b0;
  logic [2:0]  cmd_rail_in = 3'h0;
  logic [11:0] cmd_level_in = 12'h000;
  logic [6:0]  stuck = 7'h00;
  logic [6:0]  rail_good, rail_enable;
  logic [83:0] rail_level;
  logic        request, rtc_good, all_good, wake, irq_n, irq_oe_n, led;
  int          fail_count = 0;
  int          checked = 0;

  always #2 sys_clk_in = ~sys_clk_in;

  pmic_power_up_handshake #(.RAIL_TIMEOUT_CYC(50), .LED_FLASH_CYC(20)) u_pmic_power_up_handshake (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .power_present_in(power_present_in),
    .power_enable_request_in(request), .power_button_in(power_button_in),
    .memory_low_voltage_in(memory_low_voltage_in), .rail_good_in(rail_good), .cmd_valid_in(cmd_valid_in),
    .cmd_rail_in(cmd_rail_in), .cmd_enable_in(cmd_enable_in), .cmd_level_in(cmd_level_in),
    .irq_clear_in(irq_clear_in), .rail_enable_out(rail_enable), .rail_level_out(rail_level),
    .rtc_supply_good_out(rtc_good), .all_rails_good_out(all_good), .processor_wake_out(wake),
    .event_irq_n_out(irq_n), .event_irq_oe_n_out(irq_oe_n), .power_led_out(led));

  pmic_proc_model u_pmic_proc_model (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .rail_enable_in(rail_enable),
    .rtc_supply_good_in(rtc_good), .want_up_in(want_up), .stuck_in(stuck),
    .rail_good_out(rail_good), .power_enable_request_out(request));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick

  // Bounded wait for a given enable pattern
  task automatic wait_en(input logic [6:0] val, input int bound);
    int n;
    n = 0;
    while (rail_enable !== val) begin
      tick(1);
      n++;
      if (n > bound) begin
        chk("enable wait", 16'(val), 16'(rail_enable));
        close_out();
      end
    end
  endtask : wait_en

  task automatic cmd(input logic [2:0] r, input logic en, input logic [11:0] lv);
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_rail_in  <= r;
    cmd_enable_in <= en;
    cmd_level_in <= lv;
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    tick(1);
  endtask : cmd

  task automatic power_up;
    chk("reset oe_n", 16'h1, 16'(irq_oe_n));
    chk("reset cpu level", 16'h44C, 16'(rail_level[83:72]));
    @(posedge sys_clk_in);
    power_present_in <= 1'b1;
    tick(2);
    chk("rtc only", 16'h01, 16'(rail_enable));
    tick(2000);
    chk("rtc good early", 16'h0, 16'(rtc_good));
    tick(600);
    chk("rtc good", 16'h1, 16'(rtc_good));
    chk("main reset held", 16'h0, 16'(all_good));
    chk("no early strobes", 16'h01, 16'(rail_enable));
    want_up = 1'b1;
    wait_en(7'h03, 10);
    tick(2);
    chk("strobe hold", 16'h03, 16'(rail_enable));
    chk("led off", 16'h0, 16'(led));
    wait_en(7'h07, 10);
    wait_en(7'h0F, 10);
    wait_en(7'h1F, 10);
    wait_en(7'h7F, 10);
    tick(6);
    chk("all good", 16'h1, 16'(all_good));
    chk("led on", 16'h1, 16'(led));
  endtask : power_up

  task automatic commands;
    cmd(3'h6, 1'b1, 12'h5DC);
    chk("cpu level", 16'h5DC, 16'(rail_level[83:72]));
    cmd(3'h1, 1'b1, 12'h546);
    chk("mem floor", 16'h5DC, 16'(rail_level[23:12]));
    cmd(3'h0, 1'b0, 12'h000);
    chk("rtc cmd ignored", 16'h7F, 16'(rail_enable));
    cmd(3'h3, 1'b0, 12'hCE4);
    chk("rail off", 16'h77, 16'(rail_enable));
    cmd(3'h3, 1'b1, 12'hCE4);
    chk("rail on", 16'h7F, 16'(rail_enable));
    chk("core level", 16'h44C, 16'(rail_level[71:60]));
  endtask : commands

  task automatic button;
    @(posedge sys_clk_in);
    power_button_in <= 1'b1;
    tick(2);
    chk("wake", 16'h1, 16'(wake));
    chk("irq pull", 16'h0, 16'(irq_oe_n));
    chk("irq level", 16'h0, 16'(irq_n));
    power_button_in <= 1'b0;
    tick(260);
    chk("wake end", 16'h0, 16'(wake));
    chk("irq held", 16'h0, 16'(irq_oe_n));
    irq_clear_in <= 1'b1;
    @(posedge sys_clk_in);
    irq_clear_in <= 1'b0;
    tick(2);
    chk("irq release", 16'h1, 16'(irq_oe_n));
  endtask : button

  task automatic power_down;
    want_up = 1'b0;
    wait_en(7'h01, 10);
    chk("all good drop", 16'h0, 16'(all_good));
  endtask : power_down

  // Rail 3 never reports good, so the third strobe times out
  task automatic fault;
    stuck = 7'h08;
    want_up = 1'b1;
    wait_en(7'h0F, 20);
    wait_en(7'h01, 80);
    chk("fault good", 16'h0, 16'(all_good));
    tick(2);
    chk("flash on", 16'h1, 16'(led));
    tick(30);
    chk("flash off", 16'h0, 16'(led));
    tick(30);
    chk("one flash", 16'h0, 16'(led));
    want_up = 1'b0;
    stuck = 7'h00;
  endtask : fault

  // Power loss, then a mid-run reset with the low-voltage memory strap set
  task automatic low_voltage;
    @(posedge sys_clk_in);
    power_present_in <= 1'b0;
    tick(2);
    chk("power loss enables", 16'h00, 16'(rail_enable));
    chk("power loss rtc good", 16'h0, 16'(rtc_good));
    rst_b_in              <= 1'b0;
    memory_low_voltage_in <= 1'b1;
    tick(6);
    rst_b_in <= 1'b1;
    tick(2);
    power_up();
    cmd(3'h1, 1'b1, 12'h546);
    chk("mem low level", 16'h546, 16'(rail_level[23:12]));
  endtask : low_voltage

  initial begin
    tick(6);
    rst_b_in <= 1'b1;
    tick(2);
    power_up();
    commands();
    button();
    power_down();
    fault();
    low_voltage();
    close_out();
  end
endmodule : pmic_power_up_handshake_tb_top
`default_nettype wire
